//--- rtl/psr_status_id.sv
// PHY status and identifier registers with link integrity and jabber logic
`timescale 1ns/1ns
module psr_status_id #(
   parameter int TickCycles = psr_pkg::MS_CYCLES,
   parameter logic [15:0] IdHigh = psr_pkg::ID_HIGH_DEFAULT,
   parameter logic [15:0] IdLow = psr_pkg::ID_LOW_DEFAULT,
   parameter logic [4:0] PhyAddr = psr_pkg::PHY_ADDR_DEFAULT
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic mdc,
   input wire logic mdioIn,
   output logic mdioOut,
   output logic mdioOe,
   input wire logic negotiationEnable,
   input wire logic negotiationBusy,
   input wire logic codeWordStrobe,
   input wire logic partnerFaultBit,
   input wire logic linkPulse,
   input wire logic miiTransmitEnable,
   input wire logic duplexFull,
   output logic linkGood,
   output logic restartNegotiation,
   output logic jabberActive,
   output logic transmitGate,
   output logic collisionEnable,
   output logic loopbackEnable
);
   import psr_pkg::*;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // ----------------------------------------
   // Millisecond tick
   // ----------------------------------------
   logic [15:0] tickCnt_q, tickCnt_d;
   logic tick_q, tick_d;

   always_comb begin
      tick_d = (tickCnt_q == 16'(TickCycles - 1));
      tickCnt_d = tick_d ? 16'h0000 : tickCnt_q + 16'h0001;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         tickCnt_q <= 16'h0000;
         tick_q <= 1'b0;
      end else begin
         tickCnt_q <= tickCnt_d;
         tick_q <= tick_d;
      end
   end

   // ----------------------------------------
   // Link integrity and status latches
   // ----------------------------------------
   psr_link_state_type linkState_q, linkState_d;
   logic [9:0] sincePulse_q, sincePulse_d;
   logic [2:0] goodCnt_q, goodCnt_d;
   logic linkLatch_q, linkLatch_d;
   logic restart_q, restart_d;
   logic negDone_q, negDone_d;
   logic faultMirror_q, faultMirror_d;
   logic linkGood_q, linkGood_d;
   logic statusRead_q;
   logic intervalOk;
   logic failEvent;

   always_comb begin
      linkState_d = linkState_q;
      goodCnt_d = goodCnt_q;
      failEvent = 1'b0;
      intervalOk = (sincePulse_q >= LINK_MIN_MS) && (sincePulse_q <= LINK_MAX_MS);
      sincePulse_d = sincePulse_q;
      if (linkPulse) begin
         sincePulse_d = 10'h000;
      end else if (tick_q && sincePulse_q != 10'h3FF) begin
         sincePulse_d = sincePulse_q + 10'h001;
      end
      case (linkState_q)
         LNK_GOOD: begin
            if (sincePulse_q > LINK_FAIL_MS) begin
               linkState_d = LNK_FAIL;
               goodCnt_d = 3'h0;
               failEvent = 1'b1;
            end
         end
         LNK_FAIL: begin
            if (linkPulse) begin
               // Saturates so a run can wait out a busy negotiation
               goodCnt_d = !intervalOk ? 3'h0 :
                  (goodCnt_q == LINK_GOOD_PULSES) ? goodCnt_q : goodCnt_q + 3'h1;
            end
            if (goodCnt_d == LINK_GOOD_PULSES && (!negotiationEnable || !negotiationBusy)) begin
               linkState_d = LNK_GOOD;
               goodCnt_d = 3'h0;
            end
         end
         default: linkState_d = LNK_FAIL;
      endcase
      restart_d = failEvent && negotiationEnable;
      linkGood_d = (linkState_d == LNK_GOOD);
      linkLatch_d = linkLatch_q;
      if (statusRead_q && linkState_q == LNK_GOOD) begin
         linkLatch_d = 1'b1;
      end
      if (failEvent || linkState_q == LNK_FAIL) begin
         linkLatch_d = 1'b0;
      end
      // Engine busy flag also marks when negotiation registers are stable
      negDone_d = !negotiationEnable || !negotiationBusy;
      faultMirror_d = codeWordStrobe ? partnerFaultBit : faultMirror_q;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         linkState_q <= LNK_FAIL;
         sincePulse_q <= 10'h000;
         goodCnt_q <= 3'h0;
         linkLatch_q <= 1'b0;
         restart_q <= 1'b0;
         negDone_q <= 1'b1;
         faultMirror_q <= 1'b0;
         linkGood_q <= 1'b0;
      end else begin
         linkState_q <= linkState_d;
         sincePulse_q <= sincePulse_d;
         goodCnt_q <= goodCnt_d;
         linkLatch_q <= linkLatch_d;
         restart_q <= restart_d;
         negDone_q <= negDone_d;
         faultMirror_q <= faultMirror_d;
         linkGood_q <= linkGood_d;
      end
   end

   property p_fail_timeout;
      linkState_q == LNK_GOOD && sincePulse_q > LINK_FAIL_MS |=>
         linkState_q == LNK_FAIL && !linkLatch_q && !linkGood_q;
   endproperty
   a_fail_timeout: assert property (p_fail_timeout) else $error("link fail missed");
   property p_restart;
      $past(linkState_q) == LNK_GOOD && linkState_q == LNK_FAIL && $past(negotiationEnable)
         |-> restart_q ##1 !restart_q;
   endproperty
   a_restart: assert property (p_restart) else $error("no negotiation restart");
   property p_link_hold;
      !linkLatch_q && !statusRead_q |=> !linkLatch_q;
   endproperty
   a_link_hold: assert property (p_link_hold) else $error("link latch released early");
   property p_neg_done;
      negDone_q == (!$past(negotiationEnable) || !$past(negotiationBusy));
   endproperty
   a_neg_done: assert property (p_neg_done) else $error("negotiation done wrong");
   property p_fault;
      codeWordStrobe |=> faultMirror_q == $past(partnerFaultBit);
   endproperty
   a_fault: assert property (p_fault) else $error("fault mirror wrong");

   // ----------------------------------------
   // Jabber detector
   // ----------------------------------------
   psr_jab_state_type jabState_q, jabState_d;
   logic [9:0] jabCnt_q, jabCnt_d;
   logic jabLatch_q, jabLatch_d;
   logic jabActive_q, jabActive_d;
   logic txGate_q, txGate_d;
   logic colEn_q, colEn_d;
   logic loopEn_q, loopEn_d;

   always_comb begin
      jabState_d = jabState_q;
      jabCnt_d = tick_q ? jabCnt_q + 10'h001 : jabCnt_q;
      case (jabState_q)
         JAB_IDLE: begin
            jabCnt_d = 10'h000;
            if (miiTransmitEnable) begin
               jabState_d = JAB_TX;
            end
         end
         JAB_TX: begin
            if (!miiTransmitEnable) begin
               jabState_d = JAB_IDLE;
            end else if (jabCnt_q > JAB_DETECT_MS) begin
               jabState_d = JAB_ON;
            end
         end
         JAB_ON: begin
            jabCnt_d = 10'h000;
            if (!miiTransmitEnable) begin
               jabState_d = JAB_HOLD;
            end
         end
         JAB_HOLD: begin
            // Renewed transmit enable restarts the hold time
            if (miiTransmitEnable) begin
               jabState_d = JAB_ON;
            // Strictly above the hold count so tick phase never cuts the minimum
            end else if (jabCnt_q > JAB_HOLD_MS) begin
               jabState_d = JAB_IDLE;
            end
         end
         default: jabState_d = JAB_IDLE;
      endcase
      jabActive_d = (jabState_d == JAB_ON) || (jabState_d == JAB_HOLD);
      txGate_d = miiTransmitEnable && !jabActive_d;
      colEn_d = !jabActive_d;
      loopEn_d = !duplexFull && !jabActive_d;
      jabLatch_d = jabLatch_q;
      if (statusRead_q && !jabActive_q) begin
         jabLatch_d = 1'b0;
      end
      if (jabActive_d) begin
         jabLatch_d = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         jabState_q <= JAB_IDLE;
         jabCnt_q <= 10'h000;
         jabLatch_q <= 1'b0;
         jabActive_q <= 1'b0;
         txGate_q <= 1'b0;
         colEn_q <= 1'b1;
         loopEn_q <= 1'b0;
      end else begin
         jabState_q <= jabState_d;
         jabCnt_q <= jabCnt_d;
         jabLatch_q <= jabLatch_d;
         jabActive_q <= jabActive_d;
         txGate_q <= txGate_d;
         colEn_q <= colEn_d;
         loopEn_q <= loopEn_d;
      end
   end

   sequence s_hold_start;
      jabState_q == JAB_ON ##1 jabState_q == JAB_HOLD;
   endsequence
   property p_jab_hold;
      s_hold_start |-> jabActive_q [*8];
   endproperty
   a_jab_hold: assert property (p_jab_hold) else $error("jabber left too soon");
   property p_jab_detect;
      jabState_q == JAB_TX && miiTransmitEnable && jabCnt_q > JAB_DETECT_MS
         |=> jabActive_q && jabLatch_q && !txGate_q && !colEn_q;
   endproperty
   a_jab_detect: assert property (p_jab_detect) else $error("jabber not declared");
   property p_jab_keep;
      statusRead_q && jabActive_q |=> jabLatch_q;
   endproperty
   a_jab_keep: assert property (p_jab_keep) else $error("jabber released while active");

   // Cycle count in hold, checked against the tick based exit
   logic [31:0] holdCycles_q, holdCycles_d;

   always_comb begin
      holdCycles_d = (jabState_q == JAB_HOLD) ? holdCycles_q + 32'h00000001 : 32'h00000000;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         holdCycles_q <= 32'h00000000;
      end else begin
         holdCycles_q <= holdCycles_d;
      end
   end

   property p_jab_min;
      jabState_q == JAB_HOLD && jabState_d == JAB_IDLE |->
         holdCycles_q >= 32'(JAB_HOLD_MS) * 32'(TickCycles);
   endproperty
   a_jab_min: assert property (p_jab_min) else $error("jabber hold too short");

   // ----------------------------------------
   // Management frame slave
   // ----------------------------------------
   psr_md_state_type mdState_q, mdState_d;
   logic [5:0] mdCnt_q, mdCnt_d;
   logic [15:0] mdShift_q, mdShift_d;
   logic isRead_q, isRead_d;
   logic mdOut_q, mdOut_d;
   logic mdOe_q, mdOe_d;
   logic mdcPrev_q;
   logic statusRead_d;
   logic rise;
   logic [13:0] hdr;
   logic [15:0] statusWord;
   logic [15:0] readWord;

   always_comb begin
      // Link and jabber bits are driven in either media mode; software decides
      statusWord = STATUS_FIXED;
      statusWord[BIT_NEG_DONE] = negDone_q;
      statusWord[BIT_FAULT] = faultMirror_q;
      statusWord[BIT_LINK] = linkLatch_q;
      statusWord[BIT_JABBER] = jabLatch_q;
      hdr = {mdShift_q[12:0], mdioIn};
      case (hdr[4:0])
         REG_STATUS: readWord = statusWord;
         REG_ID_HIGH: readWord = IdHigh;
         REG_ID_LOW: readWord = IdLow;
         default: readWord = 16'h0000;
      endcase
      rise = mdc && !mdcPrev_q;
      mdState_d = mdState_q;
      mdCnt_d = mdCnt_q;
      mdShift_d = mdShift_q;
      isRead_d = isRead_q;
      mdOut_d = mdOut_q;
      mdOe_d = mdOe_q;
      statusRead_d = 1'b0;
      if (rise) begin
         case (mdState_q)
            MD_PRE: begin
               if (mdioIn) begin
                  mdCnt_d = (mdCnt_q == PREAMBLE_BITS) ? mdCnt_q : mdCnt_q + 6'h01;
               end else if (mdCnt_q == PREAMBLE_BITS) begin
                  mdState_d = MD_HDR;
                  mdShift_d = 16'h0000;
                  mdCnt_d = 6'h01;
               end else begin
                  mdCnt_d = 6'h00;
               end
            end
            MD_HDR: begin
               mdShift_d = {mdShift_q[14:0], mdioIn};
               mdCnt_d = mdCnt_q + 6'h01;
               if (mdCnt_q == HEADER_LAST) begin
                  mdCnt_d = 6'h00;
                  mdState_d = MD_PRE;
                  if (hdr[13:12] == FRAME_START && hdr[9:5] == PhyAddr &&
                      (hdr[11:10] == OP_READ || hdr[11:10] == OP_WRITE)) begin
                     // No isolate gating: frames are served in every mode
                     mdState_d = MD_TURN;
                     isRead_d = (hdr[11:10] == OP_READ);
                     mdShift_d = readWord;
                     statusRead_d = isRead_d && (hdr[4:0] == REG_STATUS);
                  end
               end
            end
            MD_TURN: begin
               if (mdCnt_q == 6'h00) begin
                  mdOe_d = isRead_q;
                  mdOut_d = 1'b0;
                  mdCnt_d = 6'h01;
               end else begin
                  mdState_d = MD_DATA;
                  mdCnt_d = 6'h00;
                  mdOut_d = mdShift_q[15];
                  mdShift_d = {mdShift_q[14:0], 1'b0};
               end
            end
            MD_DATA: begin
               // Write data is clocked through and dropped
               mdCnt_d = mdCnt_q + 6'h01;
               mdOut_d = mdShift_q[15];
               mdShift_d = {mdShift_q[14:0], 1'b0};
               if (mdCnt_q == DATA_LAST) begin
                  mdState_d = MD_PRE;
                  mdCnt_d = 6'h00;
                  mdOe_d = 1'b0;
                  mdOut_d = 1'b0;
               end
            end
            default: mdState_d = MD_PRE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mdState_q <= MD_PRE;
         mdCnt_q <= 6'h00;
         mdShift_q <= 16'h0000;
         isRead_q <= 1'b0;
         mdOut_q <= 1'b0;
         mdOe_q <= 1'b0;
         mdcPrev_q <= 1'b0;
         statusRead_q <= 1'b0;
      end else begin
         mdState_q <= mdState_d;
         mdCnt_q <= mdCnt_d;
         mdShift_q <= mdShift_d;
         isRead_q <= isRead_d;
         mdOut_q <= mdOut_d;
         mdOe_q <= mdOe_d;
         mdcPrev_q <= mdc;
         statusRead_q <= statusRead_d;
      end
   end

   property p_oe_idle;
      mdState_q == MD_PRE || mdState_q == MD_HDR |-> !mdOe_q;
   endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("mdio driven outside data");

   assign mdioOut = mdOut_q;
   assign mdioOe = mdOe_q;
   assign linkGood = linkGood_q;
   assign restartNegotiation = restart_q;
   assign jabberActive = jabActive_q;
   assign transmitGate = txGate_q;
   assign collisionEnable = colEn_q;
   assign loopbackEnable = loopEn_q;
endmodule

//--- rtl/psr_pkg.sv
// Constants and types shared by the PHY status and identifier block
package psr_pkg;
   // ----------------------------------------
   // Register addresses and field positions
   // ----------------------------------------
   localparam logic [4:0] REG_STATUS = 5'h01;
   localparam logic [4:0] REG_ID_HIGH = 5'h02;
   localparam logic [4:0] REG_ID_LOW = 5'h03;
   localparam int BIT_NEG_DONE = 5;
   localparam int BIT_FAULT = 4;
   localparam int BIT_LINK = 2;
   localparam int BIT_JABBER = 1;
   localparam logic [15:0] STATUS_FIXED = 16'h1809;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_HZ = 50_000_000;
   localparam int TICK_MS = 1;
   localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam logic [9:0] LINK_MIN_MS = 10'h008;
   localparam logic [9:0] LINK_MAX_MS = 10'h018;
   localparam logic [9:0] LINK_FAIL_MS = 10'h064;
   localparam logic [9:0] JAB_DETECT_MS = 10'h014;
   localparam logic [9:0] JAB_HOLD_MS = 10'h01C;
   localparam logic [2:0] LINK_GOOD_PULSES = 3'h7;
   // ----------------------------------------
   // Management frame
   // ----------------------------------------
   localparam logic [5:0] PREAMBLE_BITS = 6'h20;
   localparam logic [5:0] HEADER_LAST = 6'h0D;
   localparam logic [5:0] DATA_LAST = 6'h0F;
   localparam logic [1:0] FRAME_START = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   // Arbitrary neutral identifier values
   localparam logic [15:0] ID_HIGH_DEFAULT = 16'h0A5C;
   localparam logic [15:0] ID_LOW_DEFAULT = 16'hC3A1;
   localparam logic [4:0] PHY_ADDR_DEFAULT = 5'h00;
   // ----------------------------------------
   // State types
   // ----------------------------------------
   typedef enum logic [1:0] {
      MD_PRE = 2'b00, MD_HDR = 2'b01, MD_TURN = 2'b11, MD_DATA = 2'b10
   } psr_md_state_type;
   typedef enum logic {LNK_FAIL = 1'b0, LNK_GOOD = 1'b1} psr_link_state_type;
   typedef enum logic [1:0] {
      JAB_IDLE = 2'b00, JAB_TX = 2'b01, JAB_ON = 2'b11, JAB_HOLD = 2'b10
   } psr_jab_state_type;
endpackage

//--- dv/psr_mdio_ctl.sv
// Management controller model that runs read and write frames on MDC and MDIO
`timescale 1ns/1ns
module psr_mdio_ctl (
   input wire logic clk,
   output logic mdc,
   output logic mdioIn,
   input wire logic mdioOut,
   input wire logic mdioOe
);
   import psr_pkg::*;
   logic drv;
   // Pull-up keeps the line high whenever neither side drives it
   assign mdioIn = mdioOe ? mdioOut : drv;
   initial begin
      mdc = 1'b0;
      drv = 1'b1;
   end
   // Each half of MDC spans two system clocks, twice the least the block accepts
   task automatic one_bit(input logic b, output logic s);
      @(negedge clk);
      drv = b;
      mdc = 1'b0;
      @(negedge clk);
      @(negedge clk);
      s = mdioIn;
      mdc = 1'b1;
      @(negedge clk);
   endtask
   // Whole frame: preamble, header, turnaround, then 16 data bits MSB first
   task automatic xfer(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
         output logic [15:0] rd);
      logic [31:0] w;
      logic s;
      w = {FRAME_START, op, PHY_ADDR_DEFAULT, ra, 2'b10, wd};
      rd = 16'h0000;
      repeat (32) one_bit(1'b1, s);
      for (int i = 31; i >= 0; i--) begin
         one_bit((op == OP_READ && i < 18) ? 1'b1 : w[i], s);
         if (i < 16) rd[i] = s;
      end
      drv = 1'b1;
   endtask
endmodule

//--- dv/phy_status_id_registers_tb_top.sv
// Self-checking bench for the PHY status and identifier block
`timescale 1ns/1ns
module phy_status_id_registers_tb_top;
   import psr_pkg::*;
   // ----------------------------------------
   // Signals and reference state
   // ----------------------------------------
   localparam int TC = 40; // Short ms tick keeps the run brief
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic mdc, mdioIn, mdioOut, mdioOe;
   logic negotiationEnable = 1'b0;
   logic negotiationBusy = 1'b0;
   logic codeWordStrobe = 1'b0;
   logic partnerFaultBit = 1'b0;
   logic linkPulse = 1'b0;
   logic miiTransmitEnable = 1'b0;
   logic duplexFull = 1'b0;
   logic linkGood, restartNegotiation, jabberActive;
   logic transmitGate, collisionEnable, loopbackEnable;
   logic mGood = 1'b0;
   logic mLat = 1'b0;
   logic mJab = 1'b0;
   logic mLatJab = 1'b0;
   logic mFault = 1'b0;
   integer seed = 97921;
   int miscompares = 0;
   int checked = 0;
   int restarts = 0;
   int cycles = 0;
   always #10 clk = ~clk;
   psr_status_id #(.TickCycles(TC)) u_psr_status_id (
      .clk, .rst, .mdc, .mdioIn, .mdioOut, .mdioOe, .negotiationEnable, .negotiationBusy,
      .codeWordStrobe, .partnerFaultBit, .linkPulse, .miiTransmitEnable, .duplexFull,
      .linkGood, .restartNegotiation, .jabberActive, .transmitGate, .collisionEnable,
      .loopbackEnable);
   psr_mdio_ctl u_psr_mdio_ctl (.clk, .mdc, .mdioIn, .mdioOut, .mdioOe);
   // Ceiling about twice the expected run length
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (restartNegotiation === 1'b1) restarts <= restarts + 1;
      if (cycles == 60000) begin
         miscompares = miscompares + 1;
         print_verdict();
      end
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wait_ms(input int n);
      repeat (n * TC) @(negedge clk);
   endtask
   task automatic pulse(input int n);
      wait_ms(n);
      linkPulse = 1'b1;
      @(negedge clk);
      linkPulse = 1'b0;
      @(negedge clk);
   endtask
   // Gaps stay off the window edges, since the tick phase adds one ms of jitter
   task automatic train(input int n);
      pulse(5);
      repeat (n) pulse(10 + $unsigned($random(seed)) % 13);
   endtask
   task automatic rd(input logic [4:0] a);
      logic [15:0] v, e;
      e = 16'h0000;
      if (a == REG_STATUS)
         e = STATUS_FIXED | {10'h0, !negotiationEnable || !negotiationBusy, mFault, 1'b0,
            mLat, mLatJab, 1'b0};
      if (a == REG_ID_HIGH) e = ID_HIGH_DEFAULT;
      if (a == REG_ID_LOW) e = ID_LOW_DEFAULT;
      u_psr_mdio_ctl.xfer(OP_READ, a, 16'h0000, v);
      chk("readWord", v, e);
      if (a == REG_STATUS) begin
         if (mGood) mLat = 1'b1;
         if (!mJab) mLatJab = 1'b0;
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      logic [15:0] v;
      u_psr_mdio_ctl.xfer(OP_WRITE, a, d, v);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (20) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      chk("collisionEnable", 16'(collisionEnable), 16'h0001);
      rd(REG_STATUS);
      rd(REG_ID_HIGH);
      rd(REG_ID_LOW);
      rd(5'h07);
      wr(REG_STATUS, 16'hFFFF);
      wr(REG_ID_LOW, 16'h0000);
      rd(REG_STATUS);
      rd(REG_ID_LOW);
      for (int b = 1; b >= 0; b--) begin
         codeWordStrobe = 1'b1;
         partnerFaultBit = 1'(b);
         @(negedge clk);
         codeWordStrobe = 1'b0;
         partnerFaultBit = ~1'(b); // Flag without strobe must be ignored
         mFault = 1'(b);
         rd(REG_STATUS);
      end
      for (int e = 0; e < 2; e++) begin
         miiTransmitEnable = 1'b1;
         wait_ms(10);
         chk("transmitGate", 16'(transmitGate), 16'h0001);
         wait_ms(15);
         mJab = 1'b1;
         mLatJab = 1'b1;
         chk("jabberActive", 16'(jabberActive), 16'h0001);
         chk("gates", {13'h0, transmitGate, collisionEnable, loopbackEnable}, 16'h0000);
         miiTransmitEnable = 1'b0;
         if (e == 0) begin
            wait_ms(27);
            chk("jabberHeld", 16'(jabberActive), 16'h0001);
         end else begin
            rd(REG_STATUS);
         end
         wait_ms(e == 0 ? 3 : 30);
         mJab = 1'b0;
         chk("jabberEnd", {14'h0, jabberActive, loopbackEnable}, 16'h0001);
         rd(REG_STATUS);
         rd(REG_STATUS);
      end
      train(6);
      chk("linkGood", 16'(linkGood), 16'h0000);
      repeat (4) pulse(10 + $unsigned($random(seed)) % 13);
      mGood = 1'b1;
      chk("linkGood", 16'(linkGood), 16'h0001);
      rd(REG_STATUS);
      rd(REG_STATUS);
      wait_ms(84);
      chk("linkGood", 16'(linkGood), 16'h0001);
      wait_ms(7);
      mGood = 1'b0;
      mLat = 1'b0;
      chk("linkLost", {linkGood, 15'(restarts)}, 16'h0000);
      rd(REG_STATUS);
      negotiationEnable = 1'b1;
      negotiationBusy = 1'b1;
      rd(REG_STATUS);
      train(7);
      chk("linkGood", 16'(linkGood), 16'h0000);
      negotiationBusy = 1'b0;
      repeat (3) @(negedge clk);
      mGood = 1'b1;
      chk("linkGood", 16'(linkGood), 16'h0001);
      rd(REG_STATUS);
      wait_ms(110);
      chk("restarts", 16'(restarts), 16'h0001);
      duplexFull = 1'b1;
      repeat (3) @(negedge clk);
      chk("loopbackEnable", 16'(loopbackEnable), 16'h0000);
      print_verdict();
   end
endmodule
